// ### src/spi_mode_pkg.sv
// Package with constants and carrier types for the master serial peripheral mode.
package spi_mode_pkg;

  // ==========================================================================
  // Mode selection and frame layout
  // ==========================================================================
  localparam logic [1:0] MODE_SEL_SPI     = 2'h3;
  localparam int         DIVISOR_W        = 12;
  localparam int         FRAME_BITS       = 8;
  localparam int         BIT_CNT_W        = 4;
  localparam logic [DIVISOR_W-1:0] DIVISOR_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET       = 8'h00;
  localparam logic [3:0] LAST_EDGE        = 4'hF;
  localparam int         CLK_PERIOD_NS    = 10;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       clock_phase_bit;
    logic       clock_polarity_bit;
    logic       bit_order_select;
    logic       transmitter_enable;
    logic       receiver_enable;
    logic [1:0] operating_mode_select;
  } spi_cfg_s;

  typedef struct packed {
    logic transmit_done_flag;
    logic receive_done_flag;
    logic data_empty_flag;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic parity_error_flag;
  } spi_status_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } xfer_state_e;

endpackage : spi_mode_pkg

// ### src/baud_tick_gen.sv
// Baud tick generator: one pulse every divisor plus one system clocks.
`timescale 1ns/10ps
module baud_tick_gen
  import spi_mode_pkg::*;
#(
  parameter int DIV_W = DIVISOR_W
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  // Tick out
  output logic                  tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } baud_state_s;

  baud_state_s s_q;
  baud_state_s s_d;

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run)
    begin
      // Held at zero outside transfers so the first half period is full length.
      s_d.cnt = '0;
    end
    else if (s_q.cnt >= divisor)
    begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : baud_tick_gen

// ### src/usart_master_spi_mode.sv
// Master serial peripheral transfer controller reusing the serial transceiver resources.
//
// Summary of operation
// RQ1 - Both mode select bits high hands shifters, buffers and baud generator to SPI control.
// RQ2 - No parity, no clock recovery; one common transfer controller replaces RX/TX control.
// RQ3 - Pin control and interrupt flags behave as in normal serial mode.
// RQ4 - Software sets the serial clock pin as output before enabling.
// RQ5 - Serial clock equals system clock over two times divisor plus one.
// RQ6 - Fastest serial clock is half the system clock.
// RQ7 - Polarity and phase select modes 0 to 3 for sample and setup edges.
// RQ8 - Data shifts out and latches in on opposite serial clock edges.
// RQ9 - Software keeps polarity, phase and bit order still during transfers.
// RQ10 - Frames are exactly eight data bits, no parity or stop bits.
// RQ11 - One bit order control serves both transmitter and receiver.
// RQ12 - Next queued frame follows without gap, otherwise data line idles high.
// RQ13 - Two buffered byte writes give a 16-bit transfer, then transmit done.
// RQ14 - Transmitter works alone; receiver needs the transmitter enabled.
// RQ15 - Software holds divisor zero when enabling, then writes the real divisor.
// RQ16 - The baud divisor resets to zero.
// RQ17 - Transmit done means all sent; receive done means unread data waits.
// RQ18 - Software changes settings only when idle and clears transmit done per write.
// RQ19 - Software may disable interrupts globally during initialization.
// RQ20 - A data write starts a transfer, moving to the shifter once it is free.
// RQ21 - Enabling overrides data-out and data-in pins; clock pin carries transfer clock.
// RQ22 - On overflow the newest byte is lost; error flags read zero.
// RQ23 - Between transfers the serial clock rests at the polarity idle level.
`timescale 1ns/10ps
module usart_master_spi_mode
  import spi_mode_pkg::*;
#(
  parameter int DIV_W = DIVISOR_W
)(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Configuration
  input  wire spi_cfg_s         cfg,
  input  wire logic [DIV_W-1:0] baud_divisor,
  input  wire logic             baud_divisor_load,
  // Data buffer write and read
  input  wire logic [7:0]       data_buffer_reg_wdata,
  input  wire logic             data_buffer_reg_write,
  input  wire logic             data_buffer_reg_read,
  output logic [7:0]            data_buffer_reg_rdata,
  // Status and flag clear
  input  wire logic             transmit_done_clear,
  output spi_status_s           status,
  // Serial pins
  input  wire logic             serial_data_in,
  output logic                  serial_data_out,
  output logic                  serial_data_out_en,
  output logic                  serial_clock_pin,
  output logic                  serial_clock_pin_en,
  output logic                  data_in_override
);

  typedef struct packed {
    xfer_state_e      st;
    logic [DIV_W-1:0] divisor;
    logic [7:0]       tx_buf;
    logic             tx_buf_full;
    logic [7:0]       tx_shift;
    logic [7:0]       rx_shift;
    logic [BIT_CNT_W-1:0] edge_cnt;
    logic             sclk;
    logic             mosi;
    logic [7:0]       rx_buf;
    logic             rx_full;
    logic             tx_done;
    logic             done_pend;
    logic             mosi_en;
    logic             sclk_en;
    logic             din_ovr;
    logic [1:0]       din_sync;
  } spi_state_s;

  spi_state_s s_q;
  spi_state_s s_d;
  logic       spi_mode;
  logic       tx_on;
  logic       rx_on;
  logic       tick;
  logic       leading;
  logic       sample_now;
  logic       lead_bit;

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  assign spi_mode = (cfg.operating_mode_select == MODE_SEL_SPI); // [RQ1] [RQ2]
  assign tx_on    = spi_mode && cfg.transmitter_enable;
  assign rx_on    = tx_on && cfg.receiver_enable; // [RQ14]

  // Half-period ticks: divisor plus one clocks each, so the rate is f over 2(div+1).
  baud_tick_gen #(
    .DIV_W   (DIV_W)
  ) u_baud (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .run     (s_q.st == ST_SHIFT),
    .divisor (s_q.divisor),
    .tick    (tick)
  ); // [RQ5] [RQ6]

  // Even edge count is a leading edge; sampling on leading when phase is zero.
  assign leading    = ~s_q.edge_cnt[0];
  assign sample_now = (leading ^ cfg.clock_phase_bit); // [RQ7] [RQ8]
  assign lead_bit   = cfg.bit_order_select ? s_q.tx_shift[0] : s_q.tx_shift[7]; // [RQ11]

  // ==========================================================================
  // Transfer controller
  // ==========================================================================
  always_comb
  begin
    s_d          = s_q;
    s_d.din_sync = {s_q.din_sync[0], serial_data_in};
    s_d.mosi_en  = tx_on; // [RQ21] [RQ3]
    s_d.sclk_en  = tx_on;
    s_d.din_ovr  = rx_on;
    if (baud_divisor_load)
    begin
      s_d.divisor = baud_divisor;
    end
    if (data_buffer_reg_read)
    begin
      s_d.rx_full = 1'b0;
    end
    if (!rx_on)
    begin
      s_d.rx_full = 1'b0;
    end
    if (transmit_done_clear)
    begin
      s_d.tx_done = 1'b0;
    end
    if (s_q.done_pend)
    begin
      // Done rises one cycle after the last edge: with phase one together with the idle-high data line, with phase zero one cycle after it.
      s_d.done_pend = 1'b0;
      s_d.tx_done   = 1'b1; // [RQ13] [RQ17]
    end
    if (data_buffer_reg_write && tx_on && !s_q.tx_buf_full)
    begin
      s_d.tx_buf      = data_buffer_reg_wdata; // [RQ20]
      s_d.tx_buf_full = 1'b1;
    end
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.sclk = cfg.clock_polarity_bit; // [RQ23]
        s_d.mosi = 1'b1; // [RQ12]
        if (s_q.tx_buf_full && tx_on)
        begin
          s_d.tx_shift    = s_q.tx_buf; // [RQ20]
          s_d.tx_buf_full = 1'b0;
          s_d.edge_cnt    = '0;
          s_d.st          = ST_SHIFT;
          // Phase zero presents the first bit before the leading edge.
          if (!cfg.clock_phase_bit)
          begin
            s_d.mosi = cfg.bit_order_select ? s_q.tx_buf[0] : s_q.tx_buf[7];
          end
        end
      end
      ST_SHIFT:
      begin
        if (!tx_on)
        begin
          s_d.st = ST_IDLE;
        end
        else if (tick)
        begin
          s_d.sclk     = ~s_q.sclk; // [RQ8]
          s_d.edge_cnt = s_q.edge_cnt + 1'b1;
          if (sample_now)
          begin
            s_d.rx_shift = cfg.bit_order_select ? {s_q.din_sync[1], s_q.rx_shift[7:1]}
                                                : {s_q.rx_shift[6:0], s_q.din_sync[1]}; // [RQ11]
          end
          else if (cfg.clock_phase_bit || s_q.edge_cnt != '0)
          begin
            // Setup edge: phase one sets up on leading edges, so shift only after a sample.
            if (cfg.clock_phase_bit && s_q.edge_cnt == '0)
            begin
              s_d.mosi = lead_bit;
            end
            else
            begin
              s_d.tx_shift = cfg.bit_order_select ? {1'b0, s_q.tx_shift[7:1]}
                                                  : {s_q.tx_shift[6:0], 1'b0};
              s_d.mosi = cfg.bit_order_select ? s_q.tx_shift[1] : s_q.tx_shift[6];
            end
          end
          if (s_q.edge_cnt == LAST_EDGE) // [RQ10]
          begin
            s_d.st = ST_IDLE;
            if (rx_on)
            begin
              // Newest byte dropped when the buffer still holds unread data.
              if (!s_q.rx_full)
              begin
                // Phase zero ends on a setup edge, so the eighth sample is already in.
                s_d.rx_buf = s_d.rx_shift; // [RQ22]
              end
              s_d.rx_full = 1'b1; // [RQ17]
            end
            if (s_q.tx_buf_full)
            begin
              // Back-to-back frame keeps the clock running with no idle gap.
              s_d.tx_shift    = s_q.tx_buf; // [RQ12] [RQ13]
              s_d.tx_buf_full = 1'b0;
              s_d.edge_cnt    = '0;
              s_d.st          = ST_SHIFT;
              s_d.mosi        = cfg.clock_phase_bit ? s_q.mosi
                                : (cfg.bit_order_select ? s_q.tx_buf[0] : s_q.tx_buf[7]);
            end
            else
            begin
              // Phase one ends on a sample edge, so the last bit holds one more cycle.
              s_d.done_pend = 1'b1;
              s_d.mosi      = cfg.clock_phase_bit ? s_q.mosi : 1'b1; // [RQ12]
            end
          end
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q             <= '0;
      s_q.st          <= ST_IDLE;
      s_q.divisor     <= DIVISOR_RESET; // [RQ16]
      s_q.mosi        <= 1'b1;
      s_q.tx_buf      <= DATA_RESET;
      s_q.rx_buf      <= DATA_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign data_buffer_reg_rdata     = s_q.rx_buf;
  assign status.transmit_done_flag = s_q.tx_done;
  assign status.receive_done_flag  = s_q.rx_full;
  assign status.data_empty_flag    = ~s_q.tx_buf_full;
  assign status.framing_error_flag = 1'b0; // [RQ22]
  assign status.overrun_error_flag = 1'b0;
  assign status.parity_error_flag  = 1'b0;
  assign serial_data_out           = s_q.mosi;
  assign serial_data_out_en        = s_q.mosi_en;
  assign serial_clock_pin          = s_q.sclk;
  assign serial_clock_pin_en       = s_q.sclk_en;
  assign data_in_override          = s_q.din_ovr;

endmodule : usart_master_spi_mode

// ### bench/usart_master_spi_mode_asserts.sv
// Checker of pin and flag relations for the master serial peripheral mode.
`timescale 1ns/10ps
module usart_master_spi_mode_asserts
  import spi_mode_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Control
  input wire spi_cfg_s    cfg,
  input wire logic        data_buffer_reg_write,
  input wire logic        data_buffer_reg_read,
  input wire logic        transmit_done_clear,
  // Observed
  input wire spi_status_s status,
  input wire logic        serial_data_out,
  input wire logic        serial_data_out_en,
  input wire logic        serial_clock_pin
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic idle;
  logic take;
  assign idle = status.transmit_done_flag && status.data_empty_flag;
  assign take = data_buffer_reg_write && cfg.transmitter_enable && status.data_empty_flag;
  property p_no_err;
    1'b1 |-> !(status.framing_error_flag || status.overrun_error_flag || status.parity_error_flag);
  endproperty
  a_no_err: assert property (p_no_err) else $error("error flag set");
  // The guard on polarity leaves one cycle for the registered pin to follow a new setting.
  property p_idle_clk;
    idle && $stable(cfg.clock_polarity_bit) |-> serial_clock_pin == cfg.clock_polarity_bit;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock not at rest");
  property p_idle_dout;
    idle |-> serial_data_out;
  endproperty
  a_idle_dout: assert property (p_idle_dout) else $error("data line not idle");
  property p_load;
    take |=> !status.data_empty_flag;
  endproperty
  a_load: assert property (p_load) else $error("write not taken");
  property p_en;
    $rose(cfg.transmitter_enable) |=> serial_data_out_en;
  endproperty
  a_en: assert property (p_en) else $error("data pin not taken");
  property p_rx_off;
    !cfg.receiver_enable |=> !status.receive_done_flag;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive flag without receiver");
  property p_read;
    data_buffer_reg_read && idle |=> !status.receive_done_flag;
  endproperty
  a_read: assert property (p_read) else $error("read left flag set");
  property p_clr;
    transmit_done_clear && idle |=> !status.transmit_done_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_mode;
    cfg.operating_mode_select != MODE_SEL_SPI |=> $stable(serial_clock_pin);
  endproperty
  a_mode: assert property (p_mode) else $error("clock moved outside mode");
  c_take: cover property (take);
  c_read: cover property (data_buffer_reg_read && status.receive_done_flag);
  c_done: cover property ($rose(status.transmit_done_flag));
endmodule : usart_master_spi_mode_asserts

bind usart_master_spi_mode usart_master_spi_mode_asserts u_asserts (
  .sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg),
  .data_buffer_reg_write(data_buffer_reg_write), .data_buffer_reg_read(data_buffer_reg_read),
  .transmit_done_clear(transmit_done_clear), .status(status),
  .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
  .serial_clock_pin(serial_clock_pin)
);

// ### bench/spi_slave_model.sv
// Behavioural serial slave that sends a 16-bit stream and records the bits it samples.
`timescale 1ns/10ps
module spi_slave_model
(
  // Serial pins
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_out,
  output logic             serial_data_in,
  // Mode and stream
  input  wire logic        clock_polarity_bit,
  input  wire logic        clock_phase_bit,
  input  wire logic        load,
  input  wire logic [15:0] send,
  output logic [15:0]      seen
);
  int p = 0;
  int n = 0;
  // Past the stream the line shows the inverse of its last bit, never a held value.
  assign serial_data_in = (p < 16) ? send[15-p] : ~send[0];
  always @(serial_clock_pin or posedge load)
    if (load)
    begin
      p = 0;
      n = 0;
      seen = '0;
    end
    else if ((serial_clock_pin != clock_polarity_bit) ^ clock_phase_bit)
      seen = {seen[14:0], serial_data_out};
    else
    begin
      if (!clock_phase_bit || n > 0)
        p++;
      n++;
    end
endmodule : spi_slave_model

// ### bench/usart_master_spi_mode_tb.sv
// Self-checking bench for the master serial peripheral mode.
`timescale 1ns/10ps
module usart_master_spi_mode_tb
  import spi_mode_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  spi_cfg_s cfg;
  spi_status_s status;
  logic [11:0] div;
  logic [7:0] wdata, rdata;
  logic div_ld, wr, rd, clr, load, sdi, sdo, sdo_en, sck, sck_en, din_ov, prev;
  logic [15:0] send, seen;
  int bad_count = 0, check_count = 0, cyc = 0, last, gmin, gmax;
  always #5 sys_clk = ~sys_clk;
  // Half periods of the serial clock, in system cycles, since the last stream load.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (sck !== prev)
    begin
      if (last >= 0)
      begin
        gmin = (cyc - last < gmin) ? cyc - last : gmin;
        gmax = (cyc - last > gmax) ? cyc - last : gmax;
      end
      last = cyc;
    end
    prev = sck;
  end
  usart_master_spi_mode u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg),
    .baud_divisor(div), .baud_divisor_load(div_ld), .data_buffer_reg_wdata(wdata),
    .data_buffer_reg_write(wr), .data_buffer_reg_read(rd), .data_buffer_reg_rdata(rdata),
    .transmit_done_clear(clr), .status(status), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_en(sdo_en), .serial_clock_pin(sck),
    .serial_clock_pin_en(sck_en), .data_in_override(din_ov));
  spi_slave_model u_slave (.serial_clock_pin(sck), .serial_data_out(sdo),
    .serial_data_in(sdi), .clock_polarity_bit(cfg.clock_polarity_bit),
    .clock_phase_bit(cfg.clock_phase_bit), .load(load), .send(send), .seen(seen));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task wait_flag(input logic done);
    int n;
    n = 0;
    while ((done ? status.transmit_done_flag : status.data_empty_flag) !== 1'b1)
    begin
      tick();
      n++;
      if (n > 3000)
      begin
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        summarize();
      end
    end
  endtask : wait_flag
  task write_byte(input logic [7:0] b);
    wait_flag(1'b0);
    wdata = b;
    wr = 1'b1;
    tick();
    wr = 1'b0;
  endtask : write_byte
  // Clearing the done flag before each transfer keeps it a true end-of-transfer mark.
  task xfer(input logic [7:0] a, input logic [7:0] b, input logic [15:0] s);
    send = s;
    load = 1'b1;
    tick();
    load = 1'b0;
    last = -1;
    gmin = 999;
    gmax = 0;
    clr = 1'b1;
    tick();
    clr = 1'b0;
    write_byte(a);
    write_byte(b);
    wait_flag(1'b1);
  endtask : xfer
  function automatic logic [7:0] ord(input logic [7:0] b, input logic lsb);
    logic [7:0] r;
    r = {<<{b}};
    return lsb ? r : b;
  endfunction : ord
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    cfg = '0;
    {div, wdata, div_ld, wr, rd, clr, load, send, last, gmin, gmax} = '0;
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check(16'({status.transmit_done_flag, status.receive_done_flag, status.data_empty_flag,
      sdo, sck, sdo_en}), 16'h0C);
    cfg.operating_mode_select = MODE_SEL_SPI;
    cfg.transmitter_enable = 1'b1;
    cfg.receiver_enable = 1'b1;
    repeat (4) tick();
    check(16'({sdo_en, sck_en, din_ov}), 16'h7);
    xfer(8'hA5, 8'h3C, 16'h0);
    check(seen, 16'hA53C);
    check(16'({gmin[7:0], gmax[7:0]}), 16'h0101);
    rd = 1'b1;
    tick();
    rd = 1'b0;
    div = 12'h003;
    div_ld = 1'b1;
    tick();
    div_ld = 1'b0;
    for (int m = 0; m < 8; m++)
    begin
      cfg.clock_polarity_bit = m[1];
      cfg.clock_phase_bit = m[0];
      cfg.bit_order_select = m[2];
      repeat (4) tick();
      xfer(8'h96 + 8'(m), 8'h0F, {ord(8'hC3 ^ 8'(m), m[2]), ord(8'h5A, m[2])});
      check(seen, {ord(8'h96 + 8'(m), m[2]), ord(8'h0F, m[2])});
      check(16'({gmin[7:0], gmax[7:0]}), 16'h0404);
      check(16'({status.receive_done_flag, rdata}), 16'h100 | 16'(8'hC3 ^ 8'(m)));
      check(16'({sdo, sck}), 16'({1'b1, cfg.clock_polarity_bit}));
      rd = 1'b1;
      tick();
      rd = 1'b0;
      tick();
      check(16'(status.receive_done_flag), 16'h0);
    end
    cfg.receiver_enable = 1'b0;
    tick();
    xfer(8'h81, 8'h7E, 16'hFFFF);
    check(16'({status.receive_done_flag, din_ov}), 16'h0);
    check(seen, {ord(8'h81, 1'b1), ord(8'h7E, 1'b1)});
    cfg.operating_mode_select = 2'h1;
    repeat (3) tick();
    summarize();
  end
endmodule : usart_master_spi_mode_tb
